//--- logic/afm_monitor.sv
/*
  Alarm flag and phase fault monitor for a two-loop multiphase controller.
  Assumes synchronous sample inputs, configuration already loaded from
  nonvolatile storage, and platform logic reading the shared alarm output.
*/
`timescale 1ns/1ps
`default_nettype none
module afm_monitor #(
  parameter int unsigned PHASES = afm_pkg::AFM_PH_N
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire afm_pkg::afm_cfg_t cfg_in,
  input wire logic phase_imbalance_clear_in,
  input wire logic [afm_pkg::AFM_I_W-1:0] iout_in,
  input wire logic [afm_pkg::AFM_D_W-1:0] duty_avg_in,
  input wire logic [afm_pkg::AFM_V_W-1:0] input_voltage_sense_in,
  input wire logic [afm_pkg::AFM_T_W-1:0] temp_in,
  input wire logic ocp_in,
  input wire logic [1:0] loop_enable_in,
  input wire logic [1:0][afm_pkg::AFM_PH_N-1:0][afm_pkg::AFM_D_W-1:0] phase_duty_in,
  input wire logic [1:0][afm_pkg::AFM_PH_N-1:0] phase_active_in,
  output logic shared_alarm_oe_n_out,
  output logic thermal_warning_out,
  output logic ovp_shutdown_out,
  output logic [1:0] loop_run_out,
  output afm_pkg::afm_pf_t [1:0] phase_status_out
);
  import afm_pkg::*;

  // ------------------------------------------------------------------
  // Averaging filters
  // ------------------------------------------------------------------
  logic [AFM_ACC_W-1:0] cur_acc_q, cur_acc_d;
  logic [AFM_ACC_W-1:0] pwr_acc_q, pwr_acc_d;
  logic [AFM_I_W-1:0] cur_avg;
  logic [AFM_P_W+3:0] pwr_avg;
  logic [AFM_P_W+3:0] pwr_inst;
  logic [AFM_I_W+AFM_D_W+AFM_V_W+5:0] pwr_prod;
  logic [4:0] shift;

  // Power estimate, bandwidth pick and first-order average steps
  always_comb begin
    // Widen every factor first so the product cannot wrap at operand width
    pwr_prod = (AFM_I_W+AFM_D_W+AFM_V_W+6)'(iout_in) * (AFM_I_W+AFM_D_W+AFM_V_W+6)'(duty_avg_in)
      * (AFM_I_W+AFM_D_W+AFM_V_W+6)'(input_voltage_sense_in);
    pwr_prod = (AFM_I_W+AFM_D_W+AFM_V_W+6)'(pwr_prod * AFM_EFF_NUM / AFM_EFF_DEN);
    pwr_inst = (AFM_P_W+4)'(pwr_prod >> (AFM_D_W + 4 + 6)); // Scale to 1 W per lsb
    shift = cfg_in.cur_very_slow ? 5'(AFM_SHIFT_VSLOW) : 5'(AFM_SHIFT_SLOW);
    cur_avg = AFM_I_W'(cur_acc_q >> shift);
    pwr_avg = (AFM_P_W+4)'(pwr_acc_q >> shift);
    cur_acc_d = cur_acc_q - (cur_acc_q >> shift) + AFM_ACC_W'(iout_in);
    pwr_acc_d = pwr_acc_q - (pwr_acc_q >> shift) + AFM_ACC_W'(pwr_inst);
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cur_acc_q <= '0;
      pwr_acc_q <= '0;
    end else begin
      cur_acc_q <= cur_acc_d;
      pwr_acc_q <= pwr_acc_d;
    end
  end

  // ------------------------------------------------------------------
  // Alarm sources, hysteresis on current and power only
  // ------------------------------------------------------------------
  logic cur_alarm_q, cur_alarm_d, pwr_alarm_q, pwr_alarm_d;
  logic hot_q, hot_d, ovp_q, ovp_d, alarm_d;
  logic [AFM_I_W+4:0] cur_rel;
  logic [AFM_P_W+3:0] pwr_thr;
  logic [AFM_T_W-1:0] temp_thr;
  logic pwr_on;

  always_comb begin
    cur_rel = (AFM_I_W+5)'(cfg_in.cur_thr * AFM_HYS_NUM);
    cur_alarm_d = cur_alarm_q;
    if (!cur_alarm_q && cur_avg > cfg_in.cur_thr)
      cur_alarm_d = 1'b1;
    else if (cur_alarm_q && (AFM_I_W+5)'(cur_avg * AFM_HYS_DEN) < cur_rel)
      cur_alarm_d = 1'b0;
    pwr_thr = (AFM_P_W+4)'(cfg_in.pwr_code * AFM_PWR_STEP_W);
    if (pwr_thr > (AFM_P_W+4)'(AFM_PWR_MAX_W))
      pwr_thr = (AFM_P_W+4)'(AFM_PWR_MAX_W);
    pwr_on = pwr_thr > (AFM_P_W+4)'(AFM_PWR_MIN_W);
    pwr_alarm_d = pwr_alarm_q;
    if (!pwr_on)
      pwr_alarm_d = 1'b0;
    else if (!pwr_alarm_q && pwr_avg > pwr_thr)
      pwr_alarm_d = 1'b1;
    else if (pwr_alarm_q && pwr_avg + (AFM_P_W+4)'(AFM_PWR_HYS_W) <= pwr_thr)
      pwr_alarm_d = 1'b0;
    // Clamp warning threshold into its range
    temp_thr = cfg_in.temp_thr;
    if (temp_thr < AFM_TEMP_MIN)
      temp_thr = AFM_TEMP_MIN;
    else if (temp_thr > AFM_TEMP_MAX)
      temp_thr = AFM_TEMP_MAX;
    hot_d = temp_in > temp_thr;
    // Over-voltage latches until reset
    ovp_d = ovp_q | (cfg_in.ovp_en && input_voltage_sense_in >
      (cfg_in.ovp_div_22 ? AFM_OVP_LIM_23V5 : AFM_OVP_LIM_14V5));
    unique case (cfg_in.src_sel)
      AFM_SRC_TEMP: alarm_d = hot_q;
      AFM_SRC_TEMP_ILIM: alarm_d = hot_q | cur_alarm_q;
      AFM_SRC_TEMP_OCP: alarm_d = hot_q | ocp_in;
      AFM_SRC_ILIM: alarm_d = cur_alarm_q;
    endcase
    alarm_d = alarm_d | pwr_alarm_q;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cur_alarm_q <= 1'b0;
      pwr_alarm_q <= 1'b0;
      hot_q <= 1'b0;
      ovp_q <= 1'b0;
    end else begin
      cur_alarm_q <= cur_alarm_d;
      pwr_alarm_q <= pwr_alarm_d;
      hot_q <= hot_d;
      ovp_q <= ovp_d;
    end
  end

  // ------------------------------------------------------------------
  // Phase fault detection per loop
  // ------------------------------------------------------------------
  afm_pf_t [1:0] pf_q, pf_d;
  afm_loop_t [1:0] st_q, st_d;
  logic [1:0] en_q;

  for (genvar lp = 0; lp < 2; lp++) begin : g_loop
    logic [AFM_D_W+AFM_PH_W:0] sum;
    logic [AFM_D_W-1:0] avg;
    logic [AFM_PH_W:0] cnt;
    logic hi, lo, found;
    logic [AFM_PH_W-1:0] idx;

    // Average duty over active phases and first deviating phase
    always_comb begin
      sum = '0;
      cnt = '0;
      hi = 1'b0;
      lo = 1'b0;
      found = 1'b0;
      idx = '0;
      for (int p = 0; p < PHASES; p++) begin
        if (phase_active_in[lp][p]) begin
          sum = sum + (AFM_D_W+AFM_PH_W+1)'(phase_duty_in[lp][p]);
          cnt = cnt + 1'b1;
        end
      end
      avg = (cnt == '0) ? '0 : AFM_D_W'(sum / cnt);
      for (int p = PHASES - 1; p >= 0; p--) begin
        if (phase_active_in[lp][p] && cfg_in.phase_imbalance_enable) begin
          // One extra bit keeps the band sums from wrapping near full duty
          if ({1'b0, phase_duty_in[lp][p]} >= {1'b0, avg} + {1'b0, AFM_DUTY_DEV}) begin
            hi = 1'b1;
            found = 1'b1;
            idx = AFM_PH_W'(p);
          end else if ({1'b0, phase_duty_in[lp][p]} + {1'b0, AFM_DUTY_DEV} <= {1'b0, avg}) begin
            lo = 1'b1;
            found = 1'b1;
            idx = AFM_PH_W'(p);
          end
        end
      end
      pf_d[lp] = pf_q[lp];
      if (phase_imbalance_clear_in)
        pf_d[lp] = '0;
      if (found && st_q[lp] == AFM_LOOP_RUN) begin // Set wins over clear
        pf_d[lp].fault = 1'b1;
        pf_d[lp].faulted_phase_index = idx;
        pf_d[lp].phase_current_high = pf_d[lp].phase_current_high | hi;
        pf_d[lp].phase_current_low = pf_d[lp].phase_current_low | lo;
      end
      st_d[lp] = st_q[lp];
      unique case (st_q[lp])
        AFM_LOOP_RUN: if (found) st_d[lp] = AFM_LOOP_OFF;
        AFM_LOOP_OFF: if (en_q[lp] && !loop_enable_in[lp]) st_d[lp] = AFM_LOOP_RUN;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pf_q <= '0;
      st_q <= {AFM_LOOP_RUN, AFM_LOOP_RUN};
      en_q <= '0;
    end else begin
      pf_q <= pf_d;
      st_q <= st_d;
      en_q <= loop_enable_in;
    end
  end

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      shared_alarm_oe_n_out <= 1'b1;
      thermal_warning_out <= 1'b0;
      ovp_shutdown_out <= 1'b0;
      loop_run_out <= '0;
      phase_status_out <= '0;
    end else begin
      shared_alarm_oe_n_out <= ~alarm_d;
      thermal_warning_out <= hot_d;
      ovp_shutdown_out <= ovp_d;
      for (int l = 0; l < 2; l++)
        loop_run_out[l] <= loop_enable_in[l] && st_d[l] == AFM_LOOP_RUN && !ovp_d;
      phase_status_out <= pf_d;
    end
  end
endmodule // afm_monitor
`default_nettype wire

//--- logic/afm_pkg.sv
/*
  Package for the alarm flag and phase fault monitor: widths, fixed levels,
  alarm source selections and the packed carriers shared by the monitor.
  Assumes all sampled quantities arrive as unsigned fixed-point words.
*/
`default_nettype none
package afm_pkg;
  // --------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------
  localparam int unsigned AFM_I_W = 12; // Output current, 1/16 A per lsb
  localparam int unsigned AFM_V_W = 12; // Input voltage sense code
  localparam int unsigned AFM_D_W = 10; // Duty, 1/1024 per lsb
  localparam int unsigned AFM_P_W = 8;  // Power, 1 W per lsb
  localparam int unsigned AFM_PH_N = 8; // Phases watched per loop
  localparam int unsigned AFM_PH_W = 3;
  localparam int unsigned AFM_T_W = 8;  // Temperature, 1 degC per lsb

  // --------------------------------------------------------------------
  // Fixed levels
  // --------------------------------------------------------------------
  // Hysteresis release at 95 percent: thr * 19 / 20
  localparam int unsigned AFM_HYS_NUM = 19;
  localparam int unsigned AFM_HYS_DEN = 20;
  // Efficiency 85 percent: power = iv*d / 0.85 = iv*d*20/17
  localparam int unsigned AFM_EFF_NUM = 20;
  localparam int unsigned AFM_EFF_DEN = 17;
  localparam logic [AFM_P_W-1:0] AFM_PWR_STEP_W = 8'h04;  // 4 W per code
  localparam logic [AFM_P_W-1:0] AFM_PWR_MAX_W = 8'hFC;   // 252 W
  localparam logic [AFM_P_W-1:0] AFM_PWR_MIN_W = 8'h08;   // Active only above 8 W
  localparam logic [AFM_P_W-1:0] AFM_PWR_HYS_W = 8'h08;   // 8 W release band
  localparam logic [AFM_T_W-1:0] AFM_TEMP_MIN = 8'h40;    // 64 degC
  localparam logic [AFM_T_W-1:0] AFM_TEMP_MAX = 8'h7F;    // 127 degC
  // Duty deviation 0.05 of 1024 lsb, rounded up to 52
  localparam logic [AFM_D_W-1:0] AFM_DUTY_DEV = 10'h034;
  // Filter shifts: slow and very slow single-pole averages
  localparam int unsigned AFM_SHIFT_SLOW = 10;
  localparam int unsigned AFM_SHIFT_VSLOW = 14;
  localparam int unsigned AFM_ACC_W = AFM_P_W + 16 + AFM_SHIFT_VSLOW;
  // Input over-voltage limits in sense codes for each divider
  localparam logic [AFM_V_W-1:0] AFM_OVP_LIM_14V5 = 12'h0A6;
  localparam logic [AFM_V_W-1:0] AFM_OVP_LIM_23V5 = 12'h0AB;

  // --------------------------------------------------------------------
  // Alarm source selection
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    AFM_SRC_TEMP      = 2'h0,
    AFM_SRC_TEMP_ILIM = 2'h1,
    AFM_SRC_TEMP_OCP  = 2'h2,
    AFM_SRC_ILIM      = 2'h3
  } afm_src_t;

  // Nonvolatile configuration carrier
  typedef struct packed {
    logic [AFM_I_W-1:0] cur_thr;       // Averaged current threshold
    logic               cur_very_slow; // Filter bandwidth choice
    logic [5:0]         pwr_code;      // Power threshold in 4 W steps
    afm_src_t           src_sel;
    logic [AFM_T_W-1:0] temp_thr;      // Warning threshold, degC
    logic               ovp_en;
    logic               ovp_div_22;    // Divider 22:1 when set
    logic               phase_imbalance_enable;
  } afm_cfg_t;

  // Per-loop phase fault status carrier
  typedef struct packed {
    logic               fault;
    logic [AFM_PH_W-1:0] faulted_phase_index;
    logic               phase_current_high;
    logic               phase_current_low;
  } afm_pf_t;

  // Loop states
  typedef enum logic {AFM_LOOP_RUN, AFM_LOOP_OFF} afm_loop_t;
endpackage
`default_nettype wire

//--- verif/afm_monitor_checker.sv
/*
  Concurrent checks on the alarm and phase fault monitor ports.
  Assumes it is bound to afm_monitor and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module afm_monitor_checker import afm_pkg::*; (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire afm_cfg_t cfg_in,
  input wire logic phase_imbalance_clear_in,
  input wire logic [AFM_V_W-1:0] input_voltage_sense_in,
  input wire logic [AFM_T_W-1:0] temp_in,
  input wire logic ocp_in,
  input wire logic [1:0] loop_enable_in,
  input wire logic shared_alarm_oe_n_out,
  input wire logic thermal_warning_out,
  input wire logic ovp_shutdown_out,
  input wire logic [1:0] loop_run_out,
  input wire afm_pf_t [1:0] phase_status_out
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  logic hot;
  // Temperature above a threshold that lies in the legal range
  assign hot = temp_in > cfg_in.temp_thr && cfg_in.temp_thr >= AFM_TEMP_MIN && cfg_in.temp_thr <= AFM_TEMP_MAX;
  sequence s_hot2;
    hot [*2];
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_THERM: assert property (s_hot2 |-> ##[0:1] thermal_warning_out)
    else $error("thermal warning missing");
  AST_ALARM_TEMP: assert property (thermal_warning_out && cfg_in.src_sel != AFM_SRC_ILIM |-> ##[0:2] !shared_alarm_oe_n_out)
    else $error("alarm missing on warning");
  AST_OCP: assert property (ocp_in && cfg_in.src_sel == AFM_SRC_TEMP_OCP |-> ##[1:2] !shared_alarm_oe_n_out)
    else $error("alarm missing on over-current");
  AST_CLR: assert property (phase_imbalance_clear_in && !cfg_in.phase_imbalance_enable |=> phase_status_out == '0)
    else $error("status not cleared");
  AST_PF_DIS: assert property (!cfg_in.phase_imbalance_enable && !phase_status_out[0].fault |=> !phase_status_out[0].fault)
    else $error("fault while disabled");
  AST_LOOP_EN: assert property (!loop_enable_in[0] |=> !loop_run_out[0])
    else $error("loop runs while disabled");
  AST_FAULT_OFF: assert property ($rose(phase_status_out[0].fault) |-> !loop_run_out[0])
    else $error("faulted loop still runs");
  AST_OTHER: assert property ($rose(phase_status_out[0].fault) && !phase_status_out[1].fault && $past(loop_run_out[1]) && $past(loop_enable_in[1]) |-> loop_run_out[1])
    else $error("other loop stopped");
  AST_OVP_SET: assert property (cfg_in.ovp_en && !cfg_in.ovp_div_22 && input_voltage_sense_in > AFM_OVP_LIM_14V5 |=> ovp_shutdown_out)
    else $error("over-voltage not latched");
endmodule // afm_monitor_checker
bind afm_monitor afm_monitor_checker u_chk (.clock_in(clock_in), .srst_in(srst_in), .cfg_in(cfg_in),
  .phase_imbalance_clear_in(phase_imbalance_clear_in), .input_voltage_sense_in(input_voltage_sense_in),
  .temp_in(temp_in), .ocp_in(ocp_in), .loop_enable_in(loop_enable_in),
  .shared_alarm_oe_n_out(shared_alarm_oe_n_out), .thermal_warning_out(thermal_warning_out),
  .ovp_shutdown_out(ovp_shutdown_out), .loop_run_out(loop_run_out), .phase_status_out(phase_status_out));
`default_nettype wire

//--- verif/afm_platform_model.sv
/*
  Platform logic that watches the shared alarm pin.
  Assumes an open-drain pin with an external pull-up resistor.
*/
`timescale 1ns/1ps
`default_nettype none
module afm_platform_model (
  input wire logic oe_n_in,
  output logic pin_level_out
);
  // The pull-up sets the level whenever the monitor releases the pin
  assign pin_level_out = oe_n_in ? 1'b1 : 1'b0;
endmodule // afm_platform_model
`default_nettype wire

//--- verif/testbench.sv
/*
  Self-checking testbench for the alarm and phase fault monitor.
  Assumes afm_pkg, the monitor, its checker and the platform model.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import afm_pkg::*;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  afm_cfg_t cfg = '0;
  logic clr = 1'b0;
  logic [AFM_I_W-1:0] iout = '0;
  logic [AFM_D_W-1:0] davg = 10'h200;
  logic [AFM_V_W-1:0] vsen = '0;
  logic [AFM_T_W-1:0] temp = '0;
  logic ocp = 1'b0;
  logic [1:0] en = 2'b00;
  logic [1:0][AFM_PH_N-1:0][AFM_D_W-1:0] duty = {16{10'h200}};
  logic oe_n, hot, ovp, pin;
  logic [1:0] run;
  afm_pf_t [1:0] st;
  int fail_count = 0;
  int n_tests = 0;
  // Clock of 4 ns
  always #2 clock_in = ~clock_in;
  afm_monitor dut (.clock_in(clock_in), .srst_in(srst_in), .cfg_in(cfg), .phase_imbalance_clear_in(clr),
    .iout_in(iout), .duty_avg_in(davg), .input_voltage_sense_in(vsen), .temp_in(temp), .ocp_in(ocp),
    .loop_enable_in(en), .phase_duty_in(duty), .phase_active_in(16'hFFFF), .shared_alarm_oe_n_out(oe_n),
    .thermal_warning_out(hot), .ovp_shutdown_out(ovp), .loop_run_out(run), .phase_status_out(st));
  afm_platform_model u_plat (.oe_n_in(oe_n), .pin_level_out(pin));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_pin(input logic lvl);
    int k;
    k = 0;
    while (pin !== lvl && k < 20000) begin
      cyc(1);
      k++;
    end
    @(negedge clock_in);
    chk(pin, lvl);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    cyc(80000);
    fail_count++;
    report_and_stop();
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    cyc(20);
    @(negedge clock_in);
    chk({oe_n, run}, 3'h4);
    @(posedge clock_in);
    srst_in <= 1'b0;
    en <= 2'b11;
    cfg.temp_thr <= 8'h50;
    duty[0][5] <= 10'h240;
    cyc(4);
    @(negedge clock_in);
    chk(st, 16'h0000);
    chk(run, 2'b11);
    @(posedge clock_in);
    cfg.phase_imbalance_enable <= 1'b1;
    cyc(3);
    @(negedge clock_in);
    chk(st[0], {1'b1, 3'h5, 2'b10});
    chk(run, 2'b10);
    @(posedge clock_in);
    duty[1][2] <= 10'h1C0;
    cyc(3);
    @(negedge clock_in);
    chk(st[1], {1'b1, 3'h2, 2'b01});
    @(posedge clock_in);
    duty <= {16{10'h200}};
    cfg.phase_imbalance_enable <= 1'b0;
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(2);
    @(negedge clock_in);
    chk(st, 16'h0000);
    chk(run, 2'b00);
    @(posedge clock_in);
    en <= 2'b00;
    cyc(2);
    en <= 2'b11;
    cyc(3);
    @(negedge clock_in);
    chk(run, 2'b11);
    // Hot with no over-current, then cool with over-current, every source choice
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge clock_in);
        temp <= m ? 8'h30 : 8'h60;
        ocp <= m[0];
        cfg.src_sel <= afm_src_t'(s);
        cyc(5);
        @(negedge clock_in);
        chk(pin, m ? s != 2 : s == 3);
      end
    end
    @(posedge clock_in);
    ocp <= 1'b0;
    cfg.temp_thr <= 8'h20;
    cyc(4);
    @(negedge clock_in);
    chk(hot, 1'b0);
    @(posedge clock_in);
    cfg.src_sel <= AFM_SRC_ILIM;
    cfg.cur_thr <= 12'h100;
    iout <= 12'h200;
    wait_pin(1'b0);
    @(posedge clock_in);
    iout <= 12'h0F8;
    cyc(8000);
    @(negedge clock_in);
    chk(pin, 1'b0);
    @(posedge clock_in);
    iout <= 12'h0E0;
    wait_pin(1'b1);
    // Power alarm: about 47 W estimate, off at an 8 W setting, trips at 40 W
    @(posedge clock_in);
    cfg.cur_thr <= 12'hFFF;
    cfg.pwr_code <= 6'h02;
    iout <= 12'h200;
    vsen <= 12'h0A0;
    cyc(3000);
    @(negedge clock_in);
    chk(pin, 1'b1);
    @(posedge clock_in);
    cfg.pwr_code <= 6'h0A;
    wait_pin(1'b0);
    // Lower duty gives about 35 W: inside the 8 W band, alarm holds
    @(posedge clock_in);
    davg <= 10'h180;
    cyc(8000);
    @(negedge clock_in);
    chk(pin, 1'b0);
    // About 23 W: below threshold minus band, alarm releases
    @(posedge clock_in);
    davg <= 10'h100;
    wait_pin(1'b1);
    // Very slow filter: the slow one would trip at once, this one takes long
    @(posedge clock_in);
    cfg.pwr_code <= 6'h00;
    cfg.cur_very_slow <= 1'b1;
    cfg.cur_thr <= 12'h100;
    cyc(2000);
    @(negedge clock_in);
    chk(pin, 1'b1);
    wait_pin(1'b0);
    @(posedge clock_in);
    cfg.ovp_en <= 1'b1;
    vsen <= 12'h0A6;
    cyc(3);
    @(negedge clock_in);
    chk(ovp, 1'b0);
    @(posedge clock_in);
    vsen <= 12'h0A7;
    cyc(3);
    @(negedge clock_in);
    chk(ovp, 1'b1);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
